// File: hw/cache_query_defines.vh
`ifndef CACHE_QUERY_DEFINES_VH
`define CACHE_QUERY_DEFINES_VH

// selector value that asks for cache and translation-buffer descriptors
`define SEL_CACHE_DESC      32'h00000002
// descriptor codes
`define DESC_L0_DATA        8'h10
`define DESC_L0_INSTR       8'h15
`define DESC_L1             8'h1A
`define DESC_L2_2MB         8'h88
`define DESC_L2_4MB         8'h89
`define DESC_L2_8MB         8'h8A
`define DESC_ITB            8'h90
`define DESC_DTB0           8'h96
`define DESC_DTB1           8'h9B
`define DESC_NULL           8'h00
`define DESC_ITERATIONS     8'h01
`define DESC_FOURTH_TOP     8'h80
// level-two size configuration codes
`define L2CFG_2MB           2'h0
`define L2CFG_4MB           2'h1
`define L2CFG_8MB           2'h2
// answer word for selectors this block does not serve
`define RESULT_ZERO         32'h00000000
// word indices of the four answer words, first word lowest
`define WORD_FIRST          2'h0
`define WORD_SECOND         2'h1
`define WORD_THIRD          2'h2
`define WORD_FOURTH         2'h3

`endif

// File: hw/l2_code_select.v
`timescale 1ns/1ps
`include "cache_query_defines.vh"

// turns the fitted level-two size into its descriptor code
module l2_code_select (
   input  wire [1:0] l2SizeCfg,
   output reg  [7:0] l2Code
);
   always @* begin
      case (l2SizeCfg)
         `L2CFG_2MB: l2Code = `DESC_L2_2MB;
         `L2CFG_4MB: l2Code = `DESC_L2_4MB;
         `L2CFG_8MB: l2Code = `DESC_L2_8MB;
         // an unused setting falls back to the smallest fitted size
         default:    l2Code = `DESC_L2_2MB;
      endcase
   end
endmodule // l2_code_select

// File: hw/cache_tlb_descriptor_query.v
`timescale 1ns/1ps
`include "cache_query_defines.vh"

module cache_tlb_descriptor_query (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        clkEn,
   input  wire        queryValid,
   input  wire [31:0] querySelector,
   input  wire [1:0]  l2SizeCfg,
   output reg         resultValid,
   output reg         resultHit,
   output reg  [31:0] query_result_first,
   output reg  [31:0] query_result_second,
   output reg  [31:0] query_result_third,
   output reg  [31:0] query_result_fourth
);

   // level-two size strap: three stages, then frozen once after reset
   reg  [1:0]  strapMeta;
   reg  [1:0]  strapSync;
   reg  [1:0]  strapSettled;
   wire        strapAgree;
   reg  [1:0]  l2SizeLatched;
   reg         cfgTaken;
   wire [7:0]  l2Code;

   // decoded query and the words it would be answered with
   wire        queryTaken;
   wire        isCacheQuery;
   wire [31:0] descFirst;
   wire [31:0] descSecond;
   wire [31:0] descThird;
   wire [31:0] descFourth;

   reg         next_resultValid;
   reg         next_resultHit;
   reg  [31:0] next_query_result_first;
   reg  [31:0] next_query_result_second;
   reg  [31:0] next_query_result_third;
   reg  [31:0] next_query_result_fourth;

   // one descriptor byte per slot; a slot is the word index above the byte lane
   function [7:0] slotCode(input [3:0] slot, input [7:0] l2Desc);
      case (slot)
         4'h0:    slotCode = `DESC_ITERATIONS;
         4'h1:    slotCode = `DESC_L0_DATA;
         4'h2:    slotCode = `DESC_L0_INSTR;
         4'h3:    slotCode = `DESC_NULL;
         4'h4:    slotCode = `DESC_L1;
         4'h5:    slotCode = l2Desc;
         4'h6:    slotCode = `DESC_NULL;
         4'h7:    slotCode = `DESC_NULL;
         4'h8:    slotCode = `DESC_ITB;
         4'h9:    slotCode = `DESC_DTB0;
         4'hA:    slotCode = `DESC_DTB1;
         4'hB:    slotCode = `DESC_NULL;
         4'hC:    slotCode = `DESC_NULL;
         4'hD:    slotCode = `DESC_NULL;
         4'hE:    slotCode = `DESC_NULL;
         4'hF:    slotCode = `DESC_FOURTH_TOP;
         default: slotCode = `DESC_NULL;
      endcase
   endfunction

   // the four lanes of one result word, top lane first
   function [31:0] packWord(input [1:0] word, input [7:0] l2Desc);
      packWord = {slotCode({word, 2'h3}, l2Desc),
                  slotCode({word, 2'h2}, l2Desc),
                  slotCode({word, 2'h1}, l2Desc),
                  slotCode({word, 2'h0}, l2Desc)};
   endfunction

   // selectors this block does not serve leave every word at zero
   function [31:0] answerWord(input hit, input [31:0] desc);
      if (hit)
         answerWord = desc;
      else
         answerWord = `RESULT_ZERO;
   endfunction

   // the strap is a board pin, so it is synchronised before use; the chain is left
   // out of reset so that it has settled by the time reset is released
   always @(posedge sys_clk) begin
      if (clkEn) begin
         strapMeta    <= l2SizeCfg;
         strapSync    <= strapMeta;
         strapSettled <= strapSync;
      end
   end

   // a change counts only once the last two stages agree
   assign strapAgree = (strapSync == strapSettled);

   // caught once after reset, so a later glitch on the strap cannot move the answer;
   // a strap that is still bouncing at release is taken as soon as it settles
   always @(posedge sys_clk) begin
      if (rst) begin
         cfgTaken      <= 1'h0;
         l2SizeLatched <= `L2CFG_2MB;
      end else if (clkEn && !cfgTaken && strapAgree) begin
         cfgTaken      <= 1'h1;
         l2SizeLatched <= strapSettled;
      end
   end

   l2_code_select u_l2sel (
      .l2SizeCfg (l2SizeLatched),
      .l2Code    (l2Code)
   );

   assign queryTaken   = clkEn && queryValid;
   assign isCacheQuery = (querySelector == `SEL_CACHE_DESC);

   // every word is a constant apart from the level-two code
   assign descFirst  = packWord(`WORD_FIRST, l2Code);
   assign descSecond = packWord(`WORD_SECOND, l2Code);
   assign descThird  = packWord(`WORD_THIRD, l2Code);
   assign descFourth = packWord(`WORD_FOURTH, l2Code);

   // handshake: a one-cycle pulse per taken query; a low enable freezes it as well
   always @* begin
      next_resultValid = resultValid;
      if (clkEn) begin
         next_resultValid = queryValid;
      end
   end

   always @* begin
      next_resultHit = resultHit;
      if (queryTaken) begin
         next_resultHit = isCacheQuery;
      end
   end

   always @* begin
      next_query_result_first = query_result_first;
      if (queryTaken) begin
         next_query_result_first = answerWord(isCacheQuery, descFirst);
      end
   end

   always @* begin
      next_query_result_second = query_result_second;
      if (queryTaken) begin
         next_query_result_second = answerWord(isCacheQuery, descSecond);
      end
   end

   always @* begin
      next_query_result_third = query_result_third;
      if (queryTaken) begin
         next_query_result_third = answerWord(isCacheQuery, descThird);
      end
   end

   always @* begin
      next_query_result_fourth = query_result_fourth;
      if (queryTaken) begin
         next_query_result_fourth = answerWord(isCacheQuery, descFourth);
      end
   end

   // reset wins over a low enable so a frozen core still comes out of reset clean
   always @(posedge sys_clk) begin
      if (rst) begin
         resultValid <= 1'h0;
      end else begin
         resultValid <= next_resultValid;
      end
   end

   // the hit flag and the words stand until the next taken query
   always @(posedge sys_clk) begin
      if (rst) begin
         resultHit <= 1'h0;
      end else begin
         resultHit <= next_resultHit;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         query_result_first <= `RESULT_ZERO;
      end else begin
         query_result_first <= next_query_result_first;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         query_result_second <= `RESULT_ZERO;
      end else begin
         query_result_second <= next_query_result_second;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         query_result_third <= `RESULT_ZERO;
      end else begin
         query_result_third <= next_query_result_third;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         query_result_fourth <= `RESULT_ZERO;
      end else begin
         query_result_fourth <= next_query_result_fourth;
      end
   end

endmodule // cache_tlb_descriptor_query

// File: verif/query_issuer.sv
`timescale 1ns/1ps
module query_issuer (input wire sys_clk, output reg queryValid, output reg [31:0] querySelector);
   initial begin queryValid = 0; querySelector = 32'h0; end
   // released selector shows its inverse so a stale value is never read as valid
   task ask(input [31:0] s); begin
      @(negedge sys_clk); queryValid = 1; querySelector = s;
      @(negedge sys_clk); queryValid = 0; querySelector = ~s;
   end endtask
endmodule // query_issuer

// File: verif/cache_query_checker.sv
`timescale 1ns/1ps
module cache_query_checker (input wire sys_clk, rst, clkEn, queryValid,
   input wire [31:0] querySelector, input wire [1:0] l2SizeCfg, input wire resultValid, resultHit,
   input wire [31:0] query_result_first, query_result_second,
   input wire [31:0] query_result_third, query_result_fourth);
   wire tk = !rst && clkEn && queryValid;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   sequence s_take2; tk && querySelector == 32'h2; endsequence
   property p_first; s_take2 |=> query_result_first == 32'h00151001; endproperty
   a_first: assert property (p_first) else $error("bad first word");
   property p_second;
      s_take2 |=> query_result_second[31:16] == 16'h0 && query_result_second[7:0] == 8'h1A;
   endproperty
   a_second: assert property (p_second) else $error("bad second word");
   property p_third; s_take2 |=> query_result_third == 32'h009B9690; endproperty
   a_third: assert property (p_third) else $error("bad third word");
   property p_fourth; s_take2 |=> query_result_fourth == 32'h80000000; endproperty
   a_fourth: assert property (p_fourth) else $error("bad fourth word");
   property p_hit; tk |=> resultValid && resultHit == ($past(querySelector) == 32'h2); endproperty
   a_hit: assert property (p_hit) else $error("bad answer");
   // the strap counts at the first enabled edge after reset and is ignored afterwards
   reg [1:0] strapRef;
   reg       strapSeen;
   always @(posedge sys_clk) begin
      if (rst) begin
         strapSeen <= 1'h0;
      end else if (clkEn && !strapSeen) begin
         strapSeen <= 1'h1;
         strapRef  <= l2SizeCfg;
      end
   end
   property p_l2;
      strapSeen && resultHit |-> query_result_second[15:8] ==
         (strapRef == 2'h1 ? 8'h89 : strapRef == 2'h2 ? 8'h8A : 8'h88);
   endproperty
   a_l2: assert property (p_l2) else $error("bad size code");
   property p_idle; !tk && clkEn |=> !resultValid; endproperty
   a_idle: assert property (p_idle) else $error("spurious answer");
   property p_hold; !tk |=> $stable(query_result_second) && $stable(resultHit); endproperty
   a_hold: assert property (p_hold) else $error("answer moved");
endmodule // cache_query_checker

// File: verif/cache_tlb_descriptor_query_tb.sv
`timescale 1ns/1ps
module cache_tlb_descriptor_query_tb;
   reg sys_clk = 0, rst = 1, clkEn = 1;
   reg [1:0] l2SizeCfg = 2'h0;
   wire queryValid, resultValid, resultHit;
   wire [31:0] querySelector, query_result_first, query_result_second;
   wire [31:0] query_result_third, query_result_fourth;
   integer err_total = 0, num_checks = 0, cyc = 0, i;
   reg [32:0] rows [0:3];
   always #5 sys_clk = ~sys_clk;
   query_issuer iss (.*);
   cache_tlb_descriptor_query dut_u (.*);
   task chk(input [31:0] s, input [31:0] e); begin
      num_checks = num_checks + 1;
      if (s !== e) begin
         err_total = err_total + 1;
         $display("[ERR] %0t %h %h", $time, s, e);
      end
   end endtask
   task words(input h, input [7:0] l2); begin
      chk(resultHit, h);
      chk(query_result_first, h ? 32'h00151001 : 32'h0);
      chk(query_result_second, h ? {16'h0, l2, 8'h1A} : 32'h0);
      chk(query_result_third, h ? 32'h009B9690 : 32'h0);
      chk(query_result_fourth, h ? 32'h80000000 : 32'h0);
   end endtask
   task end_of_test; begin
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   end endtask
   always @(posedge sys_clk) begin
      cyc = cyc + 1;
      if (cyc == 500) begin err_total = err_total + 1; end_of_test; end
   end
   task hitReset; begin
      rst = 1;
      repeat (6) @(negedge sys_clk);
      rst = 0;
   end endtask
   initial begin
      rows[0] = {32'h2, 1'b1};
      rows[1] = {32'h0, 1'b0};
      rows[2] = {32'h3, 1'b0};
      rows[3] = {32'h80000002, 1'b0};
      hitReset;
      for (i = 0; i < 4; i = i + 1) begin
         iss.ask(rows[i][32:1]);
         chk(resultValid, 1'b1);
         words(rows[i][0], 8'h88);
      end
      // size strap only moves under reset since it is latched once
      for (i = 0; i < 4; i = i + 1) begin
         l2SizeCfg = i;
         hitReset;
         words(0, 8'h0);
         iss.ask(32'h2);
         words(1, i == 1 ? 8'h89 : i == 2 ? 8'h8A : 8'h88);
      end
      // a strap move outside reset must not reach the answer
      l2SizeCfg = 2'h1;
      repeat (4) @(negedge sys_clk);
      iss.ask(32'h2);
      words(1, 8'h88);
      clkEn = 0;
      iss.ask(32'h0);
      chk(resultValid, 1'h1);
      words(1, 8'h88);
      clkEn = 1;
      @(negedge sys_clk);
      chk(resultValid, 1'h0);
      words(1, 8'h88);
      end_of_test;
   end
endmodule // cache_tlb_descriptor_query_tb
bind cache_tlb_descriptor_query cache_query_checker chk_u (.*);
